// ==== hw/tacc_ctrl.sv ====
/*
 * Sequencer for one touch converter measurement: takes a command byte,
 * routes the panel, tracks, runs the 12-step approximation, holds the code.
 * Assumes mclk is the internal oscillator clock, the comparator is an
 * asynchronous analog output and the command strobe is on mclk.
 */
`timescale 1ns/1ps
`include "tacc_defs.svh"
// Function
// [RULE1] Results are straight binary, FFF to 001; the code also gives 000 when the comparator never trips
// [RULE2] Conversion timed by internal oscillator only
// [RULE3] Eight-bit command byte starts each measurement
// [RULE4] Every result delivered as twelve bits
// [RULE5] Input channel chosen from measurement type
// [RULE6] Differential reference except for auxiliary input
// [RULE7] Differential full scale spans measured axis
// [RULE8] Position samples other axis plus terminal
// [RULE9] Auxiliary: drivers off, input versus ground
// [RULE10] First pressure: X-minus, Y-plus drivers, X-plus
// [RULE11] Second pressure: same drivers, sample Y-minus
// [RULE12] Longer tracking for high-impedance sources
// [RULE13] Busy low on pen output while converting
// [RULE14] Routing fixed before tracking, held till done
module tacc_ctrl
   import tacc_pkg::*;
#(
   parameter int CODE_W = `TACC_CODE_W,
   parameter int CMD_W = `TACC_CMD_W
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Command
   input wire logic cmd_valid,
   input wire logic [CMD_W-1:0] cmd_byte,
   // Comparator from analog array
   input wire logic comp_above,
   // Panel drivers and analog routing
   output logic x_plus_terminal_ff,
   output logic x_minus_terminal_ff,
   output logic y_plus_terminal_ff,
   output logic y_minus_terminal_ff,
   output logic [2:0] ain_pos_sel_ff,
   output logic [2:0] ain_neg_sel_ff,
   output logic [2:0] ref_pos_sel_ff,
   output logic [2:0] ref_neg_sel_ff,
   output logic differential_reference_mode_ff,
   output logic single_ended_reference_mode_ff,
   output logic track_ff,
   output logic [CODE_W-1:0] dac_code_ff,
   // Result
   output logic [CODE_W-1:0] result_ff,
   output logic result_valid_ff,
   output logic pen_touch_irq_busy_n_ff
);
   tacc_route_if rif();
   tacc_route_dec u_dec (.rif(rif));

   //****************************************
   // Comparator synchroniser
   //****************************************
   logic comp_s1_ff;
   logic comp_s2_ff;
   always_ff @(posedge mclk)
   begin
      comp_s1_ff <= reset ? 1'b0 : comp_above;
      comp_s2_ff <= reset ? 1'b0 : comp_s1_ff;
   end

   //****************************************
   // Sequencer
   //****************************************
   tacc_state_e state_ff, nxt_state;
   tacc_meas_e meas_ff, nxt_meas;
   tacc_route_s route_ff, nxt_route;
   logic [15:0] cnt_ff, nxt_cnt;
   logic [CODE_W-1:0] sar_ff, nxt_sar;
   logic [CODE_W-1:0] bit_ff, nxt_bit;
   logic [CODE_W-1:0] res_ff, nxt_res;
   logic rv_ff, nxt_rv;
   logic [`TACC_TRACK_W-1:0] trk;
   always_comb
   begin
      trk = cmd_byte[`TACC_TRACK_LSB +: `TACC_TRACK_W];
      nxt_state = state_ff;
      nxt_meas = meas_ff;
      nxt_route = route_ff;
      nxt_cnt = cnt_ff;
      nxt_sar = sar_ff;
      nxt_bit = bit_ff;
      nxt_res = res_ff;
      nxt_rv = 1'b0;
      case (state_ff)
         tacc_idle:
         begin
            if (cmd_valid) // [RULE3]
            begin
               nxt_meas = tacc_meas_e'(cmd_byte[`TACC_MEAS_LSB +: `TACC_MEAS_W]);
               // Switches settle with the first tracking cycle, not one later
               nxt_route = rif.route; // [RULE5] [RULE14]
               nxt_state = tacc_track;
               // Tracking length scales with the command's track field
               nxt_cnt = `TACC_TRACK_BASE << trk; // [RULE12]
            end
         end
         tacc_track:
         begin
            nxt_route = rif.route; // [RULE5] [RULE14]
            if (cnt_ff == 16'h0000)
            begin
               nxt_state = tacc_conv;
               nxt_bit = {1'b1, {(CODE_W-1){1'b0}}};
               nxt_sar = {1'b1, {(CODE_W-1){1'b0}}};
            end
            else
            begin
               nxt_cnt = cnt_ff - 16'h0001;
            end
         end
         tacc_conv:
         begin
            // One decision per oscillator cycle, host clock never involved
            nxt_sar = comp_s2_ff ? sar_ff : (sar_ff & ~bit_ff); // [RULE2]
            nxt_bit = bit_ff >> 1;
            nxt_sar = nxt_sar | (bit_ff >> 1);
            if (bit_ff[0])
            begin
               nxt_state = tacc_done;
               nxt_res = comp_s2_ff ? sar_ff : (sar_ff & ~bit_ff); // [RULE1] [RULE4]
            end
         end
         default:
         begin
            nxt_rv = 1'b1;
            nxt_state = tacc_idle;
         end
      endcase
   end
   // Decoded straight from the command byte, so no loop through nxt_meas
   assign rif.meas = (state_ff == tacc_idle) ?
      tacc_meas_e'(cmd_byte[`TACC_MEAS_LSB +: `TACC_MEAS_W]) : meas_ff;

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         state_ff <= tacc_idle;
         meas_ff <= tacc_aux;
         route_ff <= '0;
         cnt_ff <= 16'h0000;
         sar_ff <= '0;
         bit_ff <= '0;
         res_ff <= '0;
         rv_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         meas_ff <= nxt_meas;
         route_ff <= nxt_route;
         cnt_ff <= nxt_cnt;
         sar_ff <= nxt_sar;
         bit_ff <= nxt_bit;
         res_ff <= nxt_res;
         rv_ff <= nxt_rv;
      end
   end

   //****************************************
   // Output registers
   //****************************************
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         x_plus_terminal_ff <= 1'b0;
         x_minus_terminal_ff <= 1'b0;
         y_plus_terminal_ff <= 1'b0;
         y_minus_terminal_ff <= 1'b0;
         ain_pos_sel_ff <= `TACC_SEL_AUX;
         ain_neg_sel_ff <= `TACC_SEL_GND;
         ref_pos_sel_ff <= `TACC_SEL_VDD;
         ref_neg_sel_ff <= `TACC_SEL_GND;
         differential_reference_mode_ff <= 1'b0;
         single_ended_reference_mode_ff <= 1'b1;
         track_ff <= 1'b0;
         dac_code_ff <= '0;
         result_ff <= '0;
         result_valid_ff <= 1'b0;
         pen_touch_irq_busy_n_ff <= 1'b1;
      end
      else
      begin
         x_plus_terminal_ff <= nxt_route.x_plus_drv;
         x_minus_terminal_ff <= nxt_route.x_minus_drv;
         y_plus_terminal_ff <= nxt_route.y_plus_drv;
         y_minus_terminal_ff <= nxt_route.y_minus_drv;
         ain_pos_sel_ff <= nxt_route.ain_pos;
         ain_neg_sel_ff <= nxt_route.ain_neg;
         ref_pos_sel_ff <= nxt_route.ref_pos;
         ref_neg_sel_ff <= nxt_route.ref_neg;
         differential_reference_mode_ff <= nxt_route.differential_reference_mode; // [RULE6]
         single_ended_reference_mode_ff <= ~nxt_route.differential_reference_mode;
         track_ff <= (nxt_state == tacc_track);
         dac_code_ff <= nxt_sar;
         result_ff <= nxt_res; // [RULE4]
         result_valid_ff <= nxt_rv;
         // Busy spans tracking and conversion
         pen_touch_irq_busy_n_ff <= (nxt_state == tacc_idle); // [RULE13]
      end
   end

   //****************************************
   // Checks
   //****************************************
   // Counts conversion cycles for the length check
   logic [3:0] conv_len_ff, nxt_conv_len;
   always_comb
   begin
      nxt_conv_len = (state_ff == tacc_conv) ? conv_len_ff + 4'h1 : 4'h0;
   end
   always_ff @(posedge mclk)
   begin
      conv_len_ff <= reset ? 4'h0 : nxt_conv_len;
   end

   a_route_early: assert property (@(posedge mclk) disable iff (reset) // [RULE14]
      (state_ff == tacc_track) |=> $stable(route_ff))
      else $error("Routing changed after tracking began");
   a_conv_count: assert property (@(posedge mclk) disable iff (reset) // [RULE4]
      (state_ff == tacc_done) |-> (conv_len_ff == 4'hC))
      else $error("Conversion cycle count not twelve");
   a_route_held: assert property (@(posedge mclk) disable iff (reset) // [RULE14]
      (state_ff == tacc_conv) |-> $stable(route_ff))
      else $error("Routing changed during conversion");
   a_busy_conv: assert property (@(posedge mclk) disable iff (reset) // [RULE13]
      (state_ff == tacc_conv) |=> !pen_touch_irq_busy_n_ff)
      else $error("Busy not low during conversion");
   a_cmd_start: assert property (@(posedge mclk) disable iff (reset) // [RULE3]
      (state_ff == tacc_idle && cmd_valid) |=> (state_ff == tacc_track))
      else $error("Command did not start tracking");
   a_conv_len: assert property (@(posedge mclk) disable iff (reset) // [RULE4]
      (state_ff == tacc_track && cnt_ff == 16'h0000) |=> (state_ff == tacc_conv)
      ##11 (state_ff == tacc_conv) ##1 (state_ff == tacc_done))
      else $error("Conversion not twelve steps");
   a_aux_off: assert property (@(posedge mclk) disable iff (reset) // [RULE9]
      (state_ff == tacc_conv && meas_ff == tacc_aux) |->
      !route_ff.x_plus_drv && !route_ff.y_plus_drv && !route_ff.differential_reference_mode)
      else $error("Aux routing wrong");
   a_z1_route: assert property (@(posedge mclk) disable iff (reset) // [RULE10]
      (state_ff == tacc_conv && meas_ff == tacc_z1) |->
      route_ff.x_minus_drv && route_ff.y_plus_drv && !route_ff.x_plus_drv
      && route_ff.ain_pos == `TACC_SEL_XP)
      else $error("First pressure routing wrong");
   a_z2_route: assert property (@(posedge mclk) disable iff (reset) // [RULE11]
      (state_ff == tacc_conv && meas_ff == tacc_z2) |->
      route_ff.ain_pos == `TACC_SEL_YN && route_ff.ref_pos == `TACC_SEL_YP)
      else $error("Second pressure routing wrong");
   a_x_ref: assert property (@(posedge mclk) disable iff (reset) // [RULE7]
      (state_ff == tacc_conv && meas_ff == tacc_x) |->
      route_ff.ref_pos == `TACC_SEL_XP && route_ff.ain_pos == `TACC_SEL_YP)
      else $error("X reference wrong");
   a_valid_pulse: assert property (@(posedge mclk) disable iff (reset) // [RULE1]
      result_valid_ff |=> !result_valid_ff)
      else $error("Result valid not a pulse");
endmodule : tacc_ctrl

// ==== hw/tacc_defs.svh ====
/*
 * Constants for the touch converter channel control block.
 * Assumes inclusion by bare name from the hw folder.
 */
`ifndef TACC_DEFS_SVH
`define TACC_DEFS_SVH
`define TACC_CODE_W 12
`define TACC_CMD_W 8
`define TACC_CODE_FULL 12'hFFF
`define TACC_CODE_ONE 12'h001
`define TACC_MEAS_LSB 0
`define TACC_MEAS_W 3
`define TACC_TRACK_LSB 3
`define TACC_TRACK_W 2
`define TACC_MEAS_AUX 3'h0
`define TACC_MEAS_X 3'h1
`define TACC_MEAS_Y 3'h2
`define TACC_MEAS_Z1 3'h3
`define TACC_MEAS_Z2 3'h4
`define TACC_TRACK_BASE 16'h0010
`define TACC_SEL_AUX 3'h0
`define TACC_SEL_XP 3'h1
`define TACC_SEL_XN 3'h2
`define TACC_SEL_YP 3'h3
`define TACC_SEL_YN 3'h4
`define TACC_SEL_GND 3'h5
`define TACC_SEL_VDD 3'h6
`endif

// ==== hw/tacc_pkg.sv ====
/*
 * Types for the touch converter channel control block.
 * Assumes the constants header is visible to its users.
 */
package tacc_pkg;
   typedef enum logic [2:0] {tacc_aux, tacc_x, tacc_y, tacc_z1, tacc_z2} tacc_meas_e;
   typedef enum {tacc_idle, tacc_track, tacc_conv, tacc_done} tacc_state_e;
   typedef struct packed
   {
      logic x_plus_drv;
      logic x_minus_drv;
      logic y_plus_drv;
      logic y_minus_drv;
      logic [2:0] ain_pos;
      logic [2:0] ain_neg;
      logic [2:0] ref_pos;
      logic [2:0] ref_neg;
      logic differential_reference_mode;
   } tacc_route_s;
endpackage : tacc_pkg

// ==== hw/tacc_route_dec.sv ====
/*
 * Decodes a measurement type into drivers, converter inputs and reference.
 * Assumes a purely combinational use; the caller registers the result.
 */
`timescale 1ns/1ps
`include "tacc_defs.svh"
module tacc_route_dec
   import tacc_pkg::*;
(
   tacc_route_if.dec rif
);
   always_comb
   begin
      rif.route = '0;
      case (rif.meas)
         tacc_x:
         begin
            rif.route.x_plus_drv = 1'b1;
            rif.route.x_minus_drv = 1'b1;
            rif.route.ain_pos = `TACC_SEL_YP; // [RULE8]
            rif.route.ain_neg = `TACC_SEL_XN;
            rif.route.ref_pos = `TACC_SEL_XP; // [RULE7]
            rif.route.ref_neg = `TACC_SEL_XN;
            rif.route.differential_reference_mode = 1'b1; // [RULE6]
         end
         tacc_y:
         begin
            rif.route.y_plus_drv = 1'b1;
            rif.route.y_minus_drv = 1'b1;
            rif.route.ain_pos = `TACC_SEL_XP; // [RULE8]
            rif.route.ain_neg = `TACC_SEL_YN;
            rif.route.ref_pos = `TACC_SEL_YP; // [RULE7]
            rif.route.ref_neg = `TACC_SEL_YN;
            rif.route.differential_reference_mode = 1'b1; // [RULE6]
         end
         tacc_z1:
         begin
            rif.route.x_minus_drv = 1'b1; // [RULE10]
            rif.route.y_plus_drv = 1'b1;
            rif.route.ain_pos = `TACC_SEL_XP;
            rif.route.ain_neg = `TACC_SEL_XN;
            rif.route.ref_pos = `TACC_SEL_YP;
            rif.route.ref_neg = `TACC_SEL_XN;
            rif.route.differential_reference_mode = 1'b1; // [RULE6]
         end
         tacc_z2:
         begin
            rif.route.x_minus_drv = 1'b1; // [RULE11]
            rif.route.y_plus_drv = 1'b1;
            rif.route.ain_pos = `TACC_SEL_YN;
            rif.route.ain_neg = `TACC_SEL_XN;
            rif.route.ref_pos = `TACC_SEL_YP;
            rif.route.ref_neg = `TACC_SEL_XN;
            rif.route.differential_reference_mode = 1'b1; // [RULE6]
         end
         default:
         begin
            // Drivers stay off for the auxiliary input
            rif.route.ain_pos = `TACC_SEL_AUX; // [RULE9]
            rif.route.ain_neg = `TACC_SEL_GND;
            rif.route.ref_pos = `TACC_SEL_VDD;
            rif.route.ref_neg = `TACC_SEL_GND;
         end
      endcase
   end
endmodule : tacc_route_dec

// ==== hw/tacc_route_if.sv ====
/*
 * Carries the analog routing word between the sequencer and its decoder.
 * Assumes both ends share mclk.
 */
`timescale 1ns/1ps
interface tacc_route_if;
   import tacc_pkg::*;
   tacc_meas_e meas;
   tacc_route_s route;
   modport seq (output meas, input route);
   modport dec (input meas, output route);
endinterface : tacc_route_if

// ==== sim/tacc_ctrl_tb.sv ====
/*
 * Self-checking bench for the converter channel control.
 * Assumes the panel model and the design top tacc_ctrl are compiled first.
 */
`timescale 1ns/1ps
`include "tacc_defs.svh"
module tacc_ctrl_tb
   import tacc_pkg::*;
;
   typedef struct packed
   {
      logic [2:0] m;
      logic [3:0] drv;
      logic [2:0] ap;
      logic [2:0] an;
      logic [2:0] rp;
      logic [2:0] rn;
      logic dif;
   } tacc_row_s;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic cmd_valid = 1'b0;
   logic [7:0] cmd_byte = 8'h00;
   logic comp_above;
   logic [6:0] node_high = 7'h00;
   logic xp, xn, yp, yn, dif, sng, track_ff, valid, busy_n;
   logic [2:0] ap, an, rp, rn;
   logic [11:0] dac, result;
   int failures = 0;
   int n_tests = 0;
   int t0, t3;
   tacc_row_s rows [0:4] = '{
      '{`TACC_MEAS_AUX, 4'h0, `TACC_SEL_AUX, `TACC_SEL_GND, `TACC_SEL_VDD, `TACC_SEL_GND, 1'b0},
      '{`TACC_MEAS_X, 4'hC, `TACC_SEL_YP, `TACC_SEL_XN, `TACC_SEL_XP, `TACC_SEL_XN, 1'b1},
      '{`TACC_MEAS_Y, 4'h3, `TACC_SEL_XP, `TACC_SEL_YN, `TACC_SEL_YP, `TACC_SEL_YN, 1'b1},
      '{`TACC_MEAS_Z1, 4'h6, `TACC_SEL_XP, `TACC_SEL_XN, `TACC_SEL_YP, `TACC_SEL_XN, 1'b1},
      '{`TACC_MEAS_Z2, 4'h6, `TACC_SEL_YN, `TACC_SEL_XN, `TACC_SEL_YP, `TACC_SEL_XN, 1'b1}};
   wire logic [17:0] rt_seen = {xp, xn, yp, yn, ap, an, rp, rn, dif, sng};

   //*************************************************************
   // Clock, design and panel
   //*************************************************************
   initial forever #12.5 mclk = ~mclk;

   tacc_ctrl u_dut (.mclk(mclk), .reset(reset), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
      .comp_above(comp_above), .x_plus_terminal_ff(xp), .x_minus_terminal_ff(xn),
      .y_plus_terminal_ff(yp), .y_minus_terminal_ff(yn), .ain_pos_sel_ff(ap),
      .ain_neg_sel_ff(an), .ref_pos_sel_ff(rp), .ref_neg_sel_ff(rn),
      .differential_reference_mode_ff(dif), .single_ended_reference_mode_ff(sng),
      .track_ff(track_ff), .dac_code_ff(dac), .result_ff(result),
      .result_valid_ff(valid), .pen_touch_irq_busy_n_ff(busy_n));

   tacc_panel_model u_panel (.ain_pos_sel(ap), .node_high(node_high), .comp_above(comp_above));

   //*************************************************************
   // Checks and measurement driver
   //*************************************************************
   task automatic chk(input string nm, input logic [19:0] exp, input logic [19:0] got);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : report_and_stop

   // Aux row routing doubles as the reset routing
   task automatic rst_chk();
      chk("reset routing", {2'h0, rows[0][16:0], 1'b1}, {2'h0, rt_seen});
      chk("reset status", 20'h0_0001, {6'h00, result, valid, busy_n});
   endtask : rst_chk

   // A second command mid-run is dropped when poke is set
   task automatic run_meas(input tacc_row_s r, input logic [1:0] trk, input logic lvl,
                           input logic poke, output int tcnt);
      int k;
      logic seen_conv;
      tcnt = 0;
      seen_conv = 1'b0;
      @(posedge mclk);
      node_high <= lvl ? (7'h01 << r.ap) : ~(7'h01 << r.ap);
      cmd_byte <= {3'h0, trk, r.m};
      cmd_valid <= 1'b1;
      for (k = 0; k < 400; k++)
      begin
         @(posedge mclk);
         cmd_valid <= (k == 20) && poke;
         cmd_byte <= (k == 20) ? {3'h0, trk, r.m ^ 3'h3} : cmd_byte;
         #1;
         if (valid === 1'b1)
            break;
         if (tcnt > 0 && track_ff === 1'b0 && seen_conv === 1'b0)
         begin
            seen_conv = 1'b1;
            chk("first trial", 20'h0_0800, {8'h00, dac});
         end
         if (track_ff === 1'b1)
            tcnt++;
         if (tcnt > 0)
         begin
            chk("routing", {2'h0, r[16:0], ~r.dif}, {2'h0, rt_seen});
            chk("busy", 20'h0_0000, {19'h0_0000, busy_n});
         end
      end
      if (k == 400)
      begin
         failures++;
         $display("Error result_valid expected 1 seen 0");
         report_and_stop();
      end
      chk("result", lvl ? 20'h0_0FFF : 20'h0_0000, {8'h00, result});
      chk("final trial", lvl ? 20'h0_0FFF : 20'h0_0000, {8'h00, dac});
      @(posedge mclk);
      #1;
      chk("pulse and idle", 20'h0_0001, {18'h0_0000, valid, busy_n});
   endtask : run_meas

   //*************************************************************
   // Main sequence
   //*************************************************************
   initial
   begin
      repeat (20) @(posedge mclk);
      #1;
      rst_chk();
      @(posedge mclk);
      reset <= 1'b0;
      for (int i = 0; i < 5; i++)
         run_meas(rows[i], 2'h0, i[0], 1'b0, t0);
      for (int i = 0; i < 5; i++)
         run_meas(rows[i], 2'h0, ~i[0], 1'b0, t0);
      // Longest tracking against the base length, on the X row
      run_meas(rows[1], 2'h3, 1'b1, 1'b0, t3);
      chk("track stretch", 20'd112, 20'(t3 - t0));
      run_meas(rows[3], 2'h1, 1'b1, 1'b1, t0);
      // Reset in mid-conversion drops back to the reset routing
      @(posedge mclk);
      cmd_byte <= {3'h0, 2'h0, `TACC_MEAS_Y};
      cmd_valid <= 1'b1;
      @(posedge mclk);
      cmd_valid <= 1'b0;
      repeat (22) @(posedge mclk);
      reset <= 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      rst_chk();
      @(posedge mclk);
      reset <= 1'b0;
      run_meas(rows[2], 2'h0, 1'b1, 1'b0, t0);
      report_and_stop();
   end
endmodule : tacc_ctrl_tb

// ==== sim/tacc_panel_model.sv ====
/*
 * Panel plates and auxiliary input seen by the converter comparator.
 * Assumes the bench sets node levels only between measurements.
 */
`timescale 1ns/1ps
module tacc_panel_model
(
   // Routing from the block
   input wire logic [2:0] ain_pos_sel,
   // Node levels set by the bench
   input wire logic [6:0] node_high,
   // Comparator
   output logic comp_above
);
   // A high node beats every trial code, so the result lands at an end.
   // Steady per conversion, which hides the two-cycle comparator lag.
   always_comb comp_above = (ain_pos_sel <= 3'h6) ? node_high[ain_pos_sel] : 1'b0;
endmodule : tacc_panel_model
